/* verilog/edge_event_pkg.sv */
// Constants for the line-state edge-event enable block.
// Assumes an 8-bit register port addressed by 6-bit offsets.
package edge_event_pkg;
   localparam logic [5:0] ADDR_RISE_ENABLE = 6'h0D;
   localparam logic [5:0] ADDR_RISE_SET    = 6'h0E;
   localparam logic [5:0] ADDR_RISE_CLEAR  = 6'h0F;
   localparam logic [5:0] ADDR_FALL_ENABLE = 6'h10;
   localparam int         NUM_SIGNALS      = 5;
   localparam int         BIT_ID_GROUNDED  = 4;
   localparam int         BIT_SESSION_OVER = 3;
   localparam int         BIT_SESSION_OK   = 2;
   localparam int         BIT_BUS_POWER_OK = 1;
   localparam int         BIT_HOST_DISCON  = 0;
   localparam logic [4:0] ENABLE_RESET     = 5'h1F;
   localparam logic [2:0] RESERVED_READ    = 3'h0;
   localparam int         CLOCK_HZ         = 40000000;
   localparam int         ID_SETTLE_MS     = 50;
   localparam int         ID_SETTLE_CYCLES = (CLOCK_HZ / 1000) * ID_SETTLE_MS;
endpackage

/* verilog/line_edge_detect.sv */
// One synchronised line with rising and falling edge pulses.
// Assumes an asynchronous level input and one clock domain.
`timescale 1ns/10ps
module line_edge_detect (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic level_in,
   output logic      level_sync,
   output logic      rose,
   output logic      fell
);
   logic       meta;
   logic       sync;
   logic       last;
   logic [2:0] fill;
   logic       armed;

   always_ff @(posedge clock) begin
      if (srst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
         fill <= 3'h0;
      end else begin
         meta <= level_in;
         sync <= meta;
         last <= sync;
         fill <= {fill[1:0], 1'b1};
      end
   end

   // Edges wait until the pipeline holds real samples, so a line that is
   // already high at reset release raises no false edge
   assign armed      = fill[2];
   assign level_sync = sync;
   assign rose       = armed & sync & ~last;
   assign fell       = armed & ~sync & last;
endmodule // line_edge_detect

/* verilog/phy_event_edge_enable.sv */
// Edge-enable registers and event generation for five sensed line states.
// Assumes register accesses arrive as single-cycle strobes on the clock domain.
// Notes on behaviour
// RQ1: Set alias writes ones into rise enables
// RQ2: Clear alias writes ones clear rise enables
// RQ3: Alias reads return rise enable contents
// RQ4: Both enable registers reset to all ones
// RQ5: Bits 4..0 map signals; 7..5 read zero
// RQ6: ID grounded falling edge raises event
// RQ7: ID events masked until pull-up on 50ms
// RQ8: Session end falling edge raises event
// RQ9: Session valid falling edge raises event
// RQ10: Bus power falling edge raises event
// RQ11: Host disconnect events only in host mode
// RQ12: Rising edges raise events when enabled
// RQ13: Reserved bit writes ignored, read zero
`timescale 1ns/10ps
module phy_event_edge_enable #(
   parameter int SETTLE_CYCLES = edge_event_pkg::ID_SETTLE_CYCLES
) (
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic [5:0] reg_addr,
   input  wire logic       reg_write,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]      reg_rdata,
   input  wire logic       id_pin_grounded,
   input  wire logic       session_over_level,
   input  wire logic       session_ok_level,
   input  wire logic       bus_power_ok_level,
   input  wire logic       host_disconnect_level,
   input  wire logic       id_pin_pull_up_control,
   input  wire logic       plus_line_pull_down_control,
   input  wire logic       minus_line_pull_down_control,
   output logic [4:0]      event_pulse
);
   localparam int NS = edge_event_pkg::NUM_SIGNALS;

   logic [NS-1:0] rise_enable;
   logic [NS-1:0] fall_enable;
   logic [NS-1:0] raw_level;
   logic [NS-1:0] rose;
   logic [NS-1:0] fell;
   logic [NS-1:0] next_rise_enable;
   logic [NS-1:0] next_fall_enable;
   logic [NS-1:0] allow;
   logic [NS-1:0] next_event;
   logic [25:0]   settle_count;
   logic          id_settled;
   logic          host_mode;
   logic          wr_rise;
   logic          wr_set;
   logic          wr_clear;
   logic          wr_fall;
   logic          rd_rise;
   logic          rd_fall;
   logic [NS-1:0] wbits;

   assign raw_level = {id_pin_grounded, session_over_level, session_ok_level,
                       bus_power_ok_level, host_disconnect_level};

   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_line
         line_edge_detect u_edge (
            .clock      (clock),
            .srst       (srst),
            .level_in   (raw_level[g]),
            .level_sync (),
            .rose       (rose[g]),
            .fell       (fell[g])
         );
      end
   endgenerate

   // Pull-down controls are register bits of the same clock domain
   assign host_mode = plus_line_pull_down_control & minus_line_pull_down_control; // RQ11

   always_ff @(posedge clock) begin
      if (srst || !id_pin_pull_up_control) begin
         settle_count <= 26'h0;
      end else if (!id_settled) begin
         settle_count <= settle_count + 26'h1; // RQ7
      end
   end
   assign id_settled = (settle_count >= 26'(SETTLE_CYCLES));
   assign allow = {id_pin_pull_up_control & id_settled, 3'h7, host_mode}; // RQ7 RQ11

   assign wbits    = reg_wdata[NS-1:0]; // RQ13
   assign wr_rise  = reg_write && (reg_addr == edge_event_pkg::ADDR_RISE_ENABLE);
   assign wr_set   = reg_write && (reg_addr == edge_event_pkg::ADDR_RISE_SET);
   assign wr_clear = reg_write && (reg_addr == edge_event_pkg::ADDR_RISE_CLEAR);
   assign wr_fall  = reg_write && (reg_addr == edge_event_pkg::ADDR_FALL_ENABLE);

   assign next_rise_enable = wr_rise  ? wbits :
                             wr_set   ? (rise_enable | wbits) :  // RQ1
                             wr_clear ? (rise_enable & ~wbits) : // RQ2
                             rise_enable;
   assign next_fall_enable = wr_fall ? wbits : fall_enable;

   // Event per line: enabled edge, gated by mode and settle mask
   assign next_event = ((rose & rise_enable) | (fell & fall_enable)) & allow; // RQ6 RQ8 RQ9 RQ10 RQ12

   always_ff @(posedge clock) begin
      if (srst) begin
         rise_enable <= edge_event_pkg::ENABLE_RESET; // RQ4
         fall_enable <= edge_event_pkg::ENABLE_RESET; // RQ4
         event_pulse <= 5'h00;
      end else begin
         rise_enable <= next_rise_enable;
         fall_enable <= next_fall_enable;
         event_pulse <= next_event;
      end
   end

   assign rd_rise = (reg_addr == edge_event_pkg::ADDR_RISE_ENABLE) ||
                    (reg_addr == edge_event_pkg::ADDR_RISE_SET) ||
                    (reg_addr == edge_event_pkg::ADDR_RISE_CLEAR); // RQ3
   assign rd_fall = (reg_addr == edge_event_pkg::ADDR_FALL_ENABLE);

   always_ff @(posedge clock) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (rd_rise) begin
         reg_rdata <= {edge_event_pkg::RESERVED_READ, rise_enable}; // RQ3 RQ5 RQ13
      end else if (rd_fall) begin
         reg_rdata <= {edge_event_pkg::RESERVED_READ, fall_enable}; // RQ5 RQ13
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   property p_set_alias;
      @(posedge clock) disable iff (srst)
         wr_set |=> ((rise_enable & $past(wbits)) == $past(wbits));
   endproperty
   a_set_alias: assert property (p_set_alias) else $error("set alias failed"); // RQ1

   property p_clear_alias;
      @(posedge clock) disable iff (srst)
         wr_clear |=> ((rise_enable & $past(wbits)) == 5'h00);
   endproperty
   a_clear_alias: assert property (p_clear_alias) else $error("clear alias failed"); // RQ2

   property p_alias_read;
      @(posedge clock) disable iff (srst)
         (reg_addr == edge_event_pkg::ADDR_RISE_SET) |=> (reg_rdata[4:0] == $past(rise_enable));
   endproperty
   a_alias_read: assert property (p_alias_read) else $error("alias read mismatch"); // RQ3

   property p_reset_value;
      @(posedge clock) srst |=> (rise_enable == edge_event_pkg::ENABLE_RESET &&
                                 fall_enable == edge_event_pkg::ENABLE_RESET &&
                                 event_pulse == 5'h00 && reg_rdata == 8'h00);
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("bad reset enables"); // RQ4

   property p_reserved;
      @(posedge clock) disable iff (srst) reg_rdata[7:5] == 3'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits nonzero"); // RQ5

   property p_id_mask;
      @(posedge clock) disable iff (srst) !id_pin_pull_up_control |=> !event_pulse[4];
   endproperty
   a_id_mask: assert property (p_id_mask) else $error("id event while masked"); // RQ7

   property p_host_only;
      @(posedge clock) disable iff (srst) !host_mode |=> !event_pulse[0];
   endproperty
   a_host_only: assert property (p_host_only) else $error("disconnect event outside host"); // RQ11

   sequence s_enabled_fall;
      fell[3] && fall_enable[3];
   endsequence
   property p_fall_event;
      @(posedge clock) disable iff (srst) s_enabled_fall |=> event_pulse[3];
   endproperty
   a_fall_event: assert property (p_fall_event) else $error("missed falling event"); // RQ8

   property p_rise_event;
      @(posedge clock) disable iff (srst) (rose[1] && rise_enable[1]) |=> event_pulse[1];
   endproperty
   a_rise_event: assert property (p_rise_event) else $error("missed rising event"); // RQ12

   property p_set_keep;
      @(posedge clock) disable iff (srst)
         wr_set |=> ((rise_enable & ~$past(wbits)) == ($past(rise_enable) & ~$past(wbits)));
   endproperty
   a_set_keep: assert property (p_set_keep) else $error("set alias moved zero bits"); // RQ1

   property p_clear_keep;
      @(posedge clock) disable iff (srst)
         wr_clear |=> ((rise_enable & ~$past(wbits)) == ($past(rise_enable) & ~$past(wbits)));
   endproperty
   a_clear_keep: assert property (p_clear_keep) else $error("clear alias moved zero bits"); // RQ2

   sequence s_id_fall_open;
      fell[4] && fall_enable[4] && id_pin_pull_up_control && id_settled;
   endsequence
   property p_id_fall;
      @(posedge clock) disable iff (srst) s_id_fall_open |=> event_pulse[4];
   endproperty
   a_id_fall: assert property (p_id_fall) else $error("missed id falling event"); // RQ6

   sequence s_settling;
      id_pin_pull_up_control && !id_settled;
   endsequence
   property p_settle_mask;
      @(posedge clock) disable iff (srst) s_settling |=> !event_pulse[4];
   endproperty
   a_settle_mask: assert property (p_settle_mask) else $error("id event while settling"); // RQ7

   property p_fall_off;
      @(posedge clock) disable iff (srst) (fell[3] && !fall_enable[3]) |=> !event_pulse[3];
   endproperty
   a_fall_off: assert property (p_fall_off) else $error("disabled falling event"); // RQ8

   property p_session_ok_fall;
      @(posedge clock) disable iff (srst) (fell[2] && fall_enable[2]) |=> event_pulse[2];
   endproperty
   a_session_ok_fall: assert property (p_session_ok_fall) else $error("missed session fall"); // RQ9

   property p_bus_power_fall;
      @(posedge clock) disable iff (srst) (fell[1] && fall_enable[1]) |=> event_pulse[1];
   endproperty
   a_bus_power_fall: assert property (p_bus_power_fall) else $error("missed power fall"); // RQ10

   property p_host_fall;
      @(posedge clock) disable iff (srst) (fell[0] && fall_enable[0] && host_mode) |=> event_pulse[0];
   endproperty
   a_host_fall: assert property (p_host_fall) else $error("missed disconnect fall"); // RQ11

   property p_fall_read;
      @(posedge clock) disable iff (srst) (reg_addr == edge_event_pkg::ADDR_FALL_ENABLE) |=>
         (reg_rdata == {edge_event_pkg::RESERVED_READ, $past(fall_enable)});
   endproperty
   a_fall_read: assert property (p_fall_read) else $error("fall enable read mismatch"); // RQ5
endmodule // phy_event_edge_enable

/* bench/link_model.sv */
// Link controller model issuing register writes and reads.
// Assumes the block samples requests on the rising clock edge.
`timescale 1ns/10ps
module link_model (
   input  wire logic       clock,
   output logic [5:0]      reg_addr,
   output logic            reg_write,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 6'h00;
      reg_write = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   // Read data lands one edge after the address is taken
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      @(posedge clock);
      @(posedge clock);
      d = reg_rdata;
   endtask
endmodule // link_model

/* bench/test_phy_event_edge_enable.sv */
// Self-checking bench for the edge-enable block.
// Assumes the link model above and a settle count shortened to 20.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_phy_event_edge_enable;
   logic       clock = 1'b0;
   logic       srst = 1'b1;
   logic [4:0] lv = 5'h00;
   logic       pu = 1'b1;
   logic       pd = 1'b1;
   logic       pdp = 1'b1;
   logic [5:0] reg_addr;
   logic       reg_write;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [4:0] event_pulse;
   int         miscompares = 0;
   int         check_count = 0;
   always #12.5 clock = ~clock;
   link_model link_model_inst (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   phy_event_edge_enable #(.SETTLE_CYCLES(20)) phy_event_edge_enable_inst (.clock(clock),
      .srst(srst), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .id_pin_grounded(lv[4]), .session_over_level(lv[3]),
      .session_ok_level(lv[2]), .bus_power_ok_level(lv[1]), .host_disconnect_level(lv[0]),
      .id_pin_pull_up_control(pu), .plus_line_pull_down_control(pdp),
      .minus_line_pull_down_control(pd), .event_pulse(event_pulse));
   task automatic chk_reg(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      link_model_inst.rd(a, d);
      `CHK("register", e, d)
   endtask
   // Moves the lines, then gathers every pulse over a window past the latency
   task automatic edges(input logic [4:0] v, input logic [4:0] e);
      logic [4:0] seen;
      seen = 5'h00;
      @(posedge clock);
      lv <= v;
      repeat (6) begin
         @(posedge clock);
         #1 seen = seen | event_pulse;
      end
      `CHK("events", e, seen)
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic reset_values;
      chk_reg(6'h0D, 8'h1F);
      chk_reg(6'h0E, 8'h1F);
      chk_reg(6'h0F, 8'h1F);
      chk_reg(6'h10, 8'h1F);
   endtask
   task automatic alias_access;
      link_model_inst.wr(6'h0F, 8'hE5);
      chk_reg(6'h0E, 8'h1A);
      chk_reg(6'h0F, 8'h1A);
      link_model_inst.wr(6'h0E, 8'hE1);
      chk_reg(6'h0D, 8'h1B);
      link_model_inst.wr(6'h10, 8'hF7);
      link_model_inst.wr(6'h3F, 8'hFF);
      chk_reg(6'h3F, 8'h00);
      chk_reg(6'h10, 8'h17);
   endtask
   task automatic line_events;
      edges(5'h1F, 5'h1B);
      edges(5'h00, 5'h17);
      @(posedge clock);
      pd <= 1'b0;
      edges(5'h01, 5'h00);
      edges(5'h00, 5'h00);
      @(posedge clock);
      pd <= 1'b1;
      pdp <= 1'b0;
      edges(5'h01, 5'h00);
      edges(5'h00, 5'h00);
      @(posedge clock);
      pdp <= 1'b1;
      pu <= 1'b0;
      edges(5'h10, 5'h00);
      @(posedge clock);
      pu <= 1'b1;
      edges(5'h00, 5'h00);
      repeat (25) @(posedge clock);
      edges(5'h10, 5'h10);
   endtask
   // Reset in mid-run with lines high: enables return, no false edges
   task automatic mid_reset;
      logic [4:0] seen;
      seen = 5'h00;
      link_model_inst.wr(6'h0D, 8'hE0);
      chk_reg(6'h0E, 8'h00);
      link_model_inst.wr(6'h10, 8'h00);
      chk_reg(6'h10, 8'h00);
      @(posedge clock);
      srst <= 1'b1;
      lv <= 5'h1F;
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      repeat (8) begin
         @(posedge clock);
         #1 seen = seen | event_pulse;
      end
      `CHK("reset events", 5'h00, seen)
      chk_reg(6'h0D, 8'h1F);
      chk_reg(6'h10, 8'h1F);
   endtask
   initial begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      repeat (30) @(posedge clock);
      reset_values();
      alias_access();
      line_events();
      mid_reset();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      test_done();
   end
endmodule // test_phy_event_edge_enable
